// [design/bips_selector_regs.vh]
// Functional notes
// - with nothing else set, use factory address 192.168.100.10.
// - duplicate address detected after power-on: four LED flashes per indication cycle.
// - selector 0 to 9, any value digit: request address from DHCP by device name.
// - selector A or B: DHCP/BOOTP keyed by MAC address, value switch ignored.
// - selector C: try DHCP, after 120 seconds fall back to stored parameters.
// - selector D: use stored parameters, value switch not evaluated.
// - selector E: erase stored address parameters at power-on.
// - selector F: ignore switches, derive address from factory prefix and MAC.
// - after erase, upper three bytes are 192.168.100; switches set lowest byte only.
// - switch-set lowest byte equals ten times value digit plus selector digit.
// - accept switch-set lowest byte only from 1 to 159; zero rejected.
// - after erase, while no valid parameters exist, LED double-flashes.
// - valid switch address set: LED steady; later switch change returns to double flash.
// - device-name mode label is fixed prefix plus three ASCII decimal digits.
// - changed stored parameters take effect only at next restart.
// - derived mode: 192.168.100.mac, mask 255.255.255.0, gateway equals own address.
// - derived mode: MAC byte 00 gives host 1, MAC byte FF gives host 254.
`ifndef BIPS_SELECTOR_REGS_VH
`define BIPS_SELECTOR_REGS_VH

// ****************************************
// addresses
// ****************************************
`define BIPS_FACTORY_ADDR 32'hC0A8640A
`define BIPS_NET_PREFIX 24'hC0A864
`define BIPS_PREFIX_MASK 32'hFFFFFF00
`define BIPS_HOST_NET 8'h00
`define BIPS_HOST_BCAST 8'hFF
`define BIPS_HOST_LOW 8'h01
`define BIPS_HOST_HIGH 8'hFE
`define BIPS_SWITCH_MAX 8'h9F
`define BIPS_DEC_BASE 8'h0A
`define BIPS_ASCII_ZERO 8'h30

// ****************************************
// selector positions
// ****************************************
`define BIPS_SEL_NAME_MAX 4'h9
`define BIPS_SEL_MAC_A 4'hA
`define BIPS_SEL_MAC_B 4'hB
`define BIPS_SEL_DHCP_FB 4'hC
`define BIPS_SEL_STORED 4'hD
`define BIPS_SEL_ERASE 4'hE
`define BIPS_SEL_DERIVED 4'hF

// ****************************************
// address sources
// ****************************************
`define BIPS_SRC_NONE 3'h0
`define BIPS_SRC_NAME 3'h1
`define BIPS_SRC_MAC 3'h2
`define BIPS_SRC_DHCP_FB 3'h3
`define BIPS_SRC_STORED 3'h4
`define BIPS_SRC_ERASE 3'h5
`define BIPS_SRC_DERIVED 3'h6

// ****************************************
// timing
// ****************************************
`define BIPS_CLK_HZ 40000000
`define BIPS_DHCP_TIMEOUT_S 120
`define BIPS_DHCP_TIMEOUT_CYC (33'd120 * 33'd40000000)
`define BIPS_SETTLE_MS 1000
`define BIPS_SETTLE_CYC (`BIPS_SETTLE_MS * (`BIPS_CLK_HZ / 1000))
`define BIPS_FLASH_MS 200
`define BIPS_FLASH_CYC (`BIPS_FLASH_MS * (`BIPS_CLK_HZ / 1000))
`define BIPS_CYCLE_PHASES 4'hC
`define BIPS_DUP_FLASHES 3'h4
`define BIPS_CLR_FLASHES 3'h2

`endif

// [design/bips_flash.v]
`timescale 1ns/1ps
`default_nettype none
`include "bips_selector_regs.vh"

// ****************************************
// led pattern: off, steady, or n flashes per cycle
// ****************************************
module bips_flash #(
	parameter [31:0] PHASE_CYC = `BIPS_FLASH_CYC,
	parameter [3:0] CYCLE_PHASES = `BIPS_CYCLE_PHASES
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire led_enable_i,
	input wire [2:0] flashes_i,
	output reg led_o
);
	reg [31:0] phase_cnt;
	reg [3:0] phase;
	wire phase_end;
	wire [3:0] flash_phases;

	assign phase_end = (phase_cnt >= PHASE_CYC - 32'h1);
	assign flash_phases = {flashes_i, 1'b0};

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			phase_cnt <= 32'h0;
			phase <= 4'h0;
			led_o <= 1'b0;
		end else begin
			if (phase_end) begin
				phase_cnt <= 32'h0;
				phase <= (phase >= CYCLE_PHASES - 4'h1) ? 4'h0 : phase + 4'h1;
			end else begin
				phase_cnt <= phase_cnt + 32'h1;
			end
			// even phases below twice the count are on, the rest of the cycle is the gap
			if (!led_enable_i)
				led_o <= 1'b0;
			else if (flashes_i == 3'h0)
				led_o <= 1'b1;
			else
				led_o <= (phase < flash_phases) && !phase[0];
		end
	end
endmodule // bips_flash

`default_nettype wire

// [design/bips_selector.v]
`timescale 1ns/1ps
`default_nettype none
`include "bips_selector_regs.vh"

module bips_selector #(
	parameter [32:0] DHCP_TIMEOUT_CYC = `BIPS_DHCP_TIMEOUT_CYC,
	parameter [31:0] SETTLE_CYC = `BIPS_SETTLE_CYC,
	parameter [31:0] FLASH_PHASE_CYC = `BIPS_FLASH_CYC,
	parameter integer PREFIX_CHARS = 6,
	parameter [8*PREFIX_CHARS-1:0] LABEL_PREFIX = "drive-"
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire [3:0] selector_switch_i,
	input wire [3:0] value_switch_i,
	input wire [7:0] mac_low_i,
	input wire store_valid_i,
	input wire [31:0] store_addr_i,
	input wire [31:0] store_mask_i,
	input wire [31:0] store_gw_i,
	input wire dhcp_ack_i,
	input wire [31:0] dhcp_addr_i,
	input wire [31:0] dhcp_mask_i,
	input wire [31:0] dhcp_gw_i,
	input wire dup_detect_i,
	output reg [2:0] source_o,
	output reg dhcp_request_o,
	output reg dhcp_by_name_o,
	output reg [8*PREFIX_CHARS+23:0] dhcp_host_label_o,
	output reg addr_valid_o,
	output reg [31:0] station_net_address_o,
	output reg [31:0] net_prefix_mask_o,
	output reg [31:0] gateway_o,
	output reg erase_stored_address_o,
	output reg store_write_o,
	output wire status_led_o
);
	// ****************************************
	// states
	// ****************************************
	localparam [2:0] ST_BOOT = 3'h0;
	localparam [2:0] ST_DECIDE = 3'h1;
	localparam [2:0] ST_DHCP = 3'h2;
	localparam [2:0] ST_ERASE = 3'h3;
	localparam [2:0] ST_CLRSET = 3'h4;
	localparam [2:0] ST_READY = 3'h5;

	reg [3:0] sel_meta;
	reg [3:0] sel_sync;
	reg [3:0] val_meta;
	reg [3:0] val_sync;
	reg [1:0] boot_cnt;
	reg [2:0] state;
	reg [32:0] dhcp_cnt;
	reg [31:0] settle_cnt;
	reg [7:0] last_n;
	reg committed;
	reg dup_seen;
	reg fb_ok;
	reg [31:0] fb_addr;
	reg [31:0] fb_mask;
	reg [31:0] fb_gw;
	reg led_enable;
	reg [2:0] led_flashes;

	wire [7:0] live_n;
	wire live_ok;
	wire [7:0] derived_host;
	wire [7:0] digit_h;
	wire [7:0] digit_t;
	wire [7:0] digit_u;
	wire [31:0] derived_addr;

	// ****************************************
	// switch arithmetic
	// ****************************************
	assign live_n = ({4'h0, val_sync} * `BIPS_DEC_BASE) + {4'h0, sel_sync};
	assign live_ok = (live_n != 8'h00) && (live_n <= `BIPS_SWITCH_MAX);

	// selector digit is 0..9 in name mode, so the value digit alone carries tens and hundreds
	assign digit_h = `BIPS_ASCII_ZERO + {7'h0, (val_sync >= 4'hA)};
	assign digit_t = `BIPS_ASCII_ZERO + {4'h0, (val_sync >= 4'hA) ? val_sync - 4'hA : val_sync};
	assign digit_u = `BIPS_ASCII_ZERO + {4'h0, sel_sync};

	assign derived_host = (mac_low_i == `BIPS_HOST_NET) ? `BIPS_HOST_LOW :
		(mac_low_i == `BIPS_HOST_BCAST) ? `BIPS_HOST_HIGH : mac_low_i;
	assign derived_addr = {`BIPS_NET_PREFIX, derived_host};

	// ****************************************
	// pin synchronisers
	// ****************************************
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sel_meta <= 4'h0;
			sel_sync <= 4'h0;
			val_meta <= 4'h0;
			val_sync <= 4'h0;
		end else begin
			sel_meta <= selector_switch_i;
			sel_sync <= sel_meta;
			val_meta <= value_switch_i;
			val_sync <= val_meta;
		end
	end

	// ****************************************
	// boot sequencer
	// ****************************************
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			boot_cnt <= 2'h0;
			state <= ST_BOOT;
			dhcp_cnt <= 33'h0;
			settle_cnt <= 32'h0;
			last_n <= 8'h00;
			committed <= 1'b0;
			fb_ok <= 1'b0;
			fb_addr <= 32'h0;
			fb_mask <= 32'h0;
			fb_gw <= 32'h0;
			source_o <= `BIPS_SRC_NONE;
			dhcp_request_o <= 1'b0;
			dhcp_by_name_o <= 1'b0;
			dhcp_host_label_o <= {(8*PREFIX_CHARS+24){1'b0}};
			addr_valid_o <= 1'b0;
			station_net_address_o <= `BIPS_FACTORY_ADDR;
			net_prefix_mask_o <= `BIPS_PREFIX_MASK;
			gateway_o <= `BIPS_FACTORY_ADDR;
			erase_stored_address_o <= 1'b0;
			store_write_o <= 1'b0;
		end else begin
			erase_stored_address_o <= 1'b0;
			store_write_o <= 1'b0;
			case (state)
				ST_BOOT: begin
					// wait until the synchronisers hold the real switch positions
					boot_cnt <= boot_cnt + 2'h1;
					if (boot_cnt == 2'h3)
						state <= ST_DECIDE;
				end
				ST_DECIDE: begin
					// stored parameters are taken only here, so edits apply at next restart
					fb_ok <= store_valid_i;
					fb_addr <= store_addr_i;
					fb_mask <= store_mask_i;
					fb_gw <= store_gw_i;
					dhcp_cnt <= 33'h0;
					// the single sample of the switches picks the source
					if (sel_sync <= `BIPS_SEL_NAME_MAX) begin
						source_o <= `BIPS_SRC_NAME;
						dhcp_request_o <= 1'b1;
						dhcp_by_name_o <= 1'b1;
						dhcp_host_label_o <= {LABEL_PREFIX, digit_h, digit_t, digit_u};
						state <= ST_DHCP;
					end else if (sel_sync == `BIPS_SEL_MAC_A || sel_sync == `BIPS_SEL_MAC_B) begin
						source_o <= `BIPS_SRC_MAC;
						dhcp_request_o <= 1'b1;
						state <= ST_DHCP;
					end else if (sel_sync == `BIPS_SEL_DHCP_FB) begin
						source_o <= `BIPS_SRC_DHCP_FB;
						dhcp_request_o <= 1'b1;
						state <= ST_DHCP;
					end else if (sel_sync == `BIPS_SEL_STORED) begin
						source_o <= `BIPS_SRC_STORED;
						if (store_valid_i) begin
							station_net_address_o <= store_addr_i;
							net_prefix_mask_o <= store_mask_i;
							gateway_o <= store_gw_i;
						end
						addr_valid_o <= 1'b1;
						state <= ST_READY;
					end else if (sel_sync == `BIPS_SEL_ERASE) begin
						source_o <= `BIPS_SRC_ERASE;
						erase_stored_address_o <= 1'b1;
						station_net_address_o <= {`BIPS_NET_PREFIX, 8'h00};
						net_prefix_mask_o <= `BIPS_PREFIX_MASK;
						gateway_o <= {`BIPS_NET_PREFIX, 8'h00};
						state <= ST_ERASE;
					end else begin
						source_o <= `BIPS_SRC_DERIVED;
						station_net_address_o <= derived_addr;
						net_prefix_mask_o <= `BIPS_PREFIX_MASK;
						gateway_o <= derived_addr;
						addr_valid_o <= 1'b1;
						state <= ST_READY;
					end
				end
				ST_DHCP: begin
					dhcp_cnt <= dhcp_cnt + 33'h1;
					if (dhcp_ack_i) begin
						dhcp_request_o <= 1'b0;
						station_net_address_o <= dhcp_addr_i;
						net_prefix_mask_o <= dhcp_mask_i;
						gateway_o <= dhcp_gw_i;
						addr_valid_o <= 1'b1;
						state <= ST_READY;
					end else if (source_o == `BIPS_SRC_DHCP_FB && dhcp_cnt >= DHCP_TIMEOUT_CYC - 33'h1) begin
						// no server answered in time: stored set, else the factory address
						dhcp_request_o <= 1'b0;
						if (fb_ok) begin
							station_net_address_o <= fb_addr;
							net_prefix_mask_o <= fb_mask;
							gateway_o <= fb_gw;
						end
						addr_valid_o <= 1'b1;
						state <= ST_READY;
					end
				end
				ST_ERASE: begin
					settle_cnt <= 32'h0;
					last_n <= live_n;
					committed <= 1'b0;
					state <= ST_CLRSET;
				end
				ST_CLRSET: begin
					// switches stay live here; the value must hold still before it is stored
					last_n <= live_n;
					if (live_n != last_n) begin
						settle_cnt <= 32'h0;
						committed <= 1'b0;
					end else if (settle_cnt < SETTLE_CYC - 32'h1) begin
						settle_cnt <= settle_cnt + 32'h1;
					end else if (live_ok && !committed) begin
						committed <= 1'b1;
						station_net_address_o <= {`BIPS_NET_PREFIX, live_n};
						gateway_o <= {`BIPS_NET_PREFIX, live_n};
						store_write_o <= 1'b1;
					end
				end
				ST_READY: begin
				end
				default: begin
					state <= ST_BOOT;
				end
			endcase
		end
	end

	// ****************************************
	// status indication
	// ****************************************
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dup_seen <= 1'b0;
			led_enable <= 1'b0;
			led_flashes <= 3'h0;
		end else begin
			// sticky until the next power cycle; only a reset can clear it
			if (dup_detect_i && addr_valid_o)
				dup_seen <= 1'b1;
			if (dup_seen) begin
				led_enable <= 1'b1;
				led_flashes <= `BIPS_DUP_FLASHES;
			end else if (state == ST_CLRSET) begin
				led_enable <= 1'b1;
				led_flashes <= committed ? 3'h0 : `BIPS_CLR_FLASHES;
			end else begin
				led_enable <= (state == ST_READY);
				led_flashes <= 3'h0;
			end
		end
	end

	bips_flash #(
		.PHASE_CYC(FLASH_PHASE_CYC),
		.CYCLE_PHASES(`BIPS_CYCLE_PHASES)
	) u_flash (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.led_enable_i(led_enable),
		.flashes_i(led_flashes),
		.led_o(status_led_o)
	);
endmodule // bips_selector

`default_nettype wire

// [bench/bips_selector_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bips_selector_regs.vh"
module bips_selector_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic dhcp_ack_i,
	input wire logic [31:0] dhcp_addr_i,
	input wire logic [2:0] source_o,
	input wire logic dhcp_request_o,
	input wire logic dhcp_by_name_o,
	input wire logic addr_valid_o,
	input wire logic [31:0] station_net_address_o,
	input wire logic [31:0] net_prefix_mask_o,
	input wire logic [31:0] gateway_o,
	input wire logic erase_stored_address_o,
	input wire logic store_write_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire logic drv = (source_o == `BIPS_SRC_DERIVED) && addr_valid_o;
	a_erase_one_cycle: assert property (erase_stored_address_o |=> !erase_stored_address_o)
		else $error("erase pulse longer than one cycle");
	a_erase_prefix: assert property (erase_stored_address_o |-> station_net_address_o == 32'hC0A86400)
		else $error("erase address not cleared to prefix");
	a_write_range: assert property (store_write_o |-> station_net_address_o[7:0] inside {[1:159]}
		&& station_net_address_o[31:8] == `BIPS_NET_PREFIX && gateway_o == station_net_address_o)
		else $error("stored host byte out of range");
	a_ack_loads: assert property (dhcp_request_o && dhcp_ack_i |=> addr_valid_o && !dhcp_request_o
		&& station_net_address_o == $past(dhcp_addr_i))
		else $error("server answer not taken");
	a_derived_fmt: assert property (drv |-> net_prefix_mask_o == `BIPS_PREFIX_MASK
		&& gateway_o == station_net_address_o && station_net_address_o[31:8] == `BIPS_NET_PREFIX)
		else $error("derived address format wrong");
	a_derived_edge: assert property (drv |-> !(station_net_address_o[7:0] inside {8'h00, 8'hFF}))
		else $error("derived host is network or broadcast");
	a_erase_invalid: assert property (source_o == `BIPS_SRC_ERASE |-> !addr_valid_o)
		else $error("erase mode marked address valid");
	a_source_holds: assert property (source_o != 3'h0 |=> $stable(source_o))
		else $error("source changed after boot");
	a_name_flag: assert property (dhcp_by_name_o |-> source_o == `BIPS_SRC_NAME)
		else $error("name flag outside name mode");
	a_valid_holds: assert property (addr_valid_o |=> addr_valid_o && $stable(station_net_address_o))
		else $error("address changed while running");
	c_ack: cover property (dhcp_request_o && dhcp_ack_i);
	c_write: cover property (store_write_o);
	c_derived: cover property (drv);
endmodule // bips_selector_sva
bind bips_selector bips_selector_sva bips_selector_sva_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.dhcp_ack_i(dhcp_ack_i), .dhcp_addr_i(dhcp_addr_i), .source_o(source_o), .dhcp_request_o(dhcp_request_o),
	.dhcp_by_name_o(dhcp_by_name_o), .addr_valid_o(addr_valid_o), .station_net_address_o(station_net_address_o),
	.net_prefix_mask_o(net_prefix_mask_o), .gateway_o(gateway_o),
	.erase_stored_address_o(erase_stored_address_o), .store_write_o(store_write_o));
`default_nettype wire

// [bench/bips_dhcp_srv.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// address server: answers a request after a chosen delay, or stays silent
// ****************************************
module bips_dhcp_srv (
	input wire logic core_clk_i,
	input wire logic request_i,
	input wire logic enable_i,
	input wire logic [7:0] delay_i,
	input wire logic [31:0] offer_i,
	output logic ack_o = 1'b0,
	output logic [31:0] addr_o = 32'h0,
	output logic [31:0] mask_o = 32'h0,
	output logic [31:0] gw_o = 32'h0
);
	int cnt = 0;
	always @(posedge core_clk_i) begin
		#1;
		ack_o = 1'b0;
		// words are only valid with the ack, so they toggle otherwise
		addr_o = ~addr_o;
		mask_o = ~mask_o;
		gw_o = ~gw_o;
		if (!request_i) cnt = 0;
		else if (enable_i && cnt >= 0) begin
			if (cnt == delay_i) begin
				ack_o = 1'b1;
				addr_o = offer_i;
				mask_o = 32'hFFFF0000;
				gw_o = offer_i ^ 32'h1;
				cnt = -1;
			end else cnt++;
		end
	end
endmodule // bips_dhcp_srv
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "bips_selector_regs.vh"
module tb_top;
	logic clk = 0, rst_n = 0, serve = 1, svalid = 1, ack, req, byname, valid, erase, wr, pv = 0, dup = 0, led, pl;
	logic [31:0] smask = 32'hFFFF0000, sgw = 32'h0A000101;
	int flashes = 0;
	logic [3:0] sel = 0, val = 0;
	logic [7:0] mac = 0, dly = 0;
	logic [2:0] src;
	logic [71:0] label;
	logic [31:0] sa = 32'h0A000105, offer = 0, da, dm, dg, addr, mask, gw, m;
	logic [31:0] q[$];
	int fail_count = 0, tests_run = 0, erases = 0;
	always #12.5 clk = ~clk;
	bips_dhcp_srv bips_dhcp_srv_i (.core_clk_i(clk), .request_i(req), .enable_i(serve), .delay_i(dly),
		.offer_i(offer), .ack_o(ack), .addr_o(da), .mask_o(dm), .gw_o(dg));
	bips_selector #(.DHCP_TIMEOUT_CYC(33'd100), .SETTLE_CYC(8), .FLASH_PHASE_CYC(4)) bips_selector_i (
		.core_clk_i(clk), .rst_n_i(rst_n), .selector_switch_i(sel), .value_switch_i(val), .mac_low_i(mac),
		.store_valid_i(svalid), .store_addr_i(sa), .store_mask_i(smask), .store_gw_i(sgw),
		.dhcp_ack_i(ack), .dhcp_addr_i(da), .dhcp_mask_i(dm), .dhcp_gw_i(dg), .dup_detect_i(dup),
		.source_o(src), .dhcp_request_o(req), .dhcp_by_name_o(byname), .dhcp_host_label_o(label),
		.addr_valid_o(valid), .station_net_address_o(addr), .net_prefix_mask_o(mask), .gateway_o(gw),
		.erase_stored_address_o(erase), .store_write_o(wr), .status_led_o(led));
	task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ****************************************
	// result watcher: each new address pops the oldest expectation
	// ****************************************
	always @(posedge clk) begin
		if (erase === 1'b1) erases++;
		if (rst_n && ((valid === 1'b1 && !pv) || wr === 1'b1)) begin
			if (q.size() == 0) check("unexpected address", addr, 72'h0);
			else check("address", addr, q.pop_front());
		end
		pv = (valid === 1'b1);
	end
	// switches settle under reset, so the boot sample is well over two cycles old
	task automatic boot(input logic [3:0] s, input logic [3:0] v);
		@(posedge clk) #1;
		rst_n = 0;
		sel = s;
		val = v;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic drain(input string nm);
		for (int i = 0; i < 300 && q.size() != 0; i++) @(posedge clk);
		check("pending results", q.size(), 0);
		$display("test %s done", nm);
	endtask
	task automatic dial(input logic [3:0] s, input logic [3:0] v);
		sel = s;
		val = v;
		repeat (30) @(posedge clk);
		#1;
	endtask
	initial begin
		void'($urandom(57273));
		repeat (2) @(posedge clk);
		#1 check("factory address", addr, `BIPS_FACTORY_ADDR);
		for (int i = 0; i < 3; i++) begin
			offer = $urandom;
			dly = $urandom % 20;
			q.push_back(offer);
			boot(i == 0 ? 4'h3 : 4'h9 + i, 4'hC);
			check("source", src, i == 0 ? `BIPS_SRC_NAME : `BIPS_SRC_MAC);
			if (i == 0) check("label", label, {"drive-", "123"});
			drain("dhcp");
		end
		serve = 0;
		q.push_back(sa);
		boot(4'hC, 4'h0);
		repeat (90) @(posedge clk);
		check("early fallback", valid, 1'b0);
		drain("fallback");
		q.push_back(sa);
		smask = $urandom;
		sgw = $urandom;
		boot(4'hD, 4'h7);
		check("stored mask", mask, smask);
		check("stored gateway", gw, sgw);
		dial(4'h0, 4'h1);
		check("stored kept", addr, sa);
		svalid = 0;
		q.push_back(`BIPS_FACTORY_ADDR);
		boot(4'hD, 4'h2);
		drain("stored");
		for (int i = 0; i < 4; i++) begin
			m = (i == 0) ? 0 : (i == 1) ? 8'hFF : $urandom;
			mac = m[7:0];
			q.push_back({`BIPS_NET_PREFIX, (m[7:0] == 0) ? 8'h01 : (m[7:0] == 8'hFF) ? 8'hFE : m[7:0]});
			boot(4'hF, $urandom);
			drain("derived");
		end
		// conflict pulse while the derived address is in use; count led rises over one indication cycle
		dup = 1;
		@(posedge clk) #1 dup = 0;
		repeat (5) @(posedge clk);
		#1 pl = led;
		flashes = 0;
		for (int i = 0; i < 48; i++) begin
			@(posedge clk) #1;
			if (led === 1'b1 && pl !== 1'b1) flashes++;
			pl = led;
		end
		check("dup flashes", flashes, 4);
		$display("test dup done");
		erases = 0;
		boot(4'hE, 4'h9);
		check("erase pulses", erases, 1);
		check("erase address", addr, 32'hC0A86400);
		dial(4'h0, 4'h0);
		q.push_back(32'hC0A86419);
		dial(4'h5, 4'h2);
		check("led steady", led, 1'b1);
		dial(4'hA, 4'hF);
		q.push_back(32'hC0A8649F);
		dial(4'h9, 4'hF);
		drain("erase");
		complete_run();
	end
	initial begin
		#(25 * 6000);
		fail_count++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
